// ===== core/asc_pkg.sv
// Constants and types for the converter sampling and conversion control
package asc_pkg;

   // ----------------------------------------------------------------
   // Clock rates and converter clock divider
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned ADC_CLK_MAX_HZ = 5_200_000;
   localparam int unsigned ADC_MAX_SPS = 200_000;
   // Least divide ratio that keeps the converter clock at or under max
   localparam int unsigned ADC_DIV_INT =
      (CLK_HZ + ADC_CLK_MAX_HZ - 1) / ADC_CLK_MAX_HZ;
   localparam logic [3:0] ADC_DIV = 4'(ADC_DIV_INT);

   // ----------------------------------------------------------------
   // Conversion cycle budget, in converter clock ticks
   // ----------------------------------------------------------------
   localparam int unsigned CYCLE_TICKS_INT = 26;
   localparam int unsigned SETTLE_SHORT_INT = 4;
   localparam int unsigned SETTLE_LONG_INT = 10;
   localparam logic [4:0] SETTLE_SHORT = 5'(SETTLE_SHORT_INT);
   localparam logic [4:0] SETTLE_LONG = 5'(SETTLE_LONG_INT);
   localparam logic [4:0] CONV_TICKS =
      5'(CYCLE_TICKS_INT - SETTLE_SHORT_INT);

   // ----------------------------------------------------------------
   // Result hand-off delay after busy falls, register-port cycles
   // ----------------------------------------------------------------
   localparam logic [4:0] EOC_DELAY = 5'h10;

   // ----------------------------------------------------------------
   // Averaging select and widths
   // ----------------------------------------------------------------
   localparam logic [8:0] AVG_NONE = 9'h001;
   localparam logic [8:0] AVG_16 = 9'h010;
   localparam logic [8:0] AVG_64 = 9'h040;
   localparam logic [8:0] AVG_256 = 9'h100;
   localparam int unsigned RESULT_W = 16;
   localparam int unsigned AUX_N = 16;
   localparam logic [3:0] COMMON_N_RESET = 4'h0;

   typedef enum logic [1:0] {
      ASC_IDLE,
      ASC_SETTLE,
      ASC_CONVERT
   } asc_state_e;

endpackage

// ===== core/asc_start_sync.sv
// Start request synchroniser: OR of start pulse and start clock
`timescale 1ns/100ps
`default_nettype none
module asc_start_sync
   import asc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_conversion_start_pulse,
   input wire logic i_conversion_start_clock,
   output logic o_start_rise
);

   typedef struct packed {
      logic [1:0] pulse_sync;
      logic [1:0] clock_sync;
      logic prev;
      logic rise;
   } asc_sync_s;

   asc_sync_s st;
   asc_sync_s next_st;

   always_comb begin
      next_st = st;
      next_st.pulse_sync = {st.pulse_sync[0], i_conversion_start_pulse};
      next_st.clock_sync = {st.clock_sync[0], i_conversion_start_clock};
      // Only second stages are combined, first stages feed nothing else
      next_st.prev = st.pulse_sync[1] | st.clock_sync[1];
      next_st.rise = (st.pulse_sync[1] | st.clock_sync[1]) & ~st.prev;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_start_rise = st.rise;

endmodule // asc_start_sync
`default_nettype wire

// ===== core/asc_ctrl.sv
// Sampling and conversion control for the monitor converter
// ------------------------------------------------------------------
// Behaviour
// - Continuous mode converts back to back, 26 ticks, or 32 with extended settling
// - Next channel comes from operating mode input
// - Converter clock divided to at most 5.2 MHz
// - Normal settling lasts four converter ticks
// - Extended settling lasts ten converter ticks
// - Single bit or sequencer field selects extension
// - Event mode converts only on a start
// - Event mode ignores the extended settling bit
// - Track-and-hold takes next channel at busy rise
// - Start pulse and start clock are ORed
// - Start request resynchronised to converter clock
// - Running conversion is never aborted by starts
// - Result and end-of-conversion 16 cycles after busy
// - End of sequence with last sequenced channel
// - End of sequence after all averaged samples
// - At most one conversion per start request; starts during a conversion get none
// - Only connected aux pairs become analog inputs
// - Analog aux pin loses its digital use
// - Shared-negative source picks the common reference
// - Up to 16 aux inputs, rest stay digital
// - Result is 16 bits stored whole
// ------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module asc_ctrl
   import asc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_event_mode,
   input wire logic i_extended_settling_bit,
   input wire logic [2:0] i_sequencer_settling_field,
   input wire logic i_sequencer_active,
   input wire logic [4:0] i_sequence_length,
   input wire logic i_averaging_select_low,
   input wire logic i_averaging_select_high,
   input wire logic [4:0] i_next_channel,
   input wire logic [15:0] i_sample_code,
   input wire logic i_conversion_start_pulse,
   input wire logic i_conversion_start_clock,
   input wire logic [15:0] i_aux_connected,
   input wire logic i_single_ended_analog_standard,
   input wire logic [3:0] i_common_n_source,
   output logic o_busy,
   output logic o_eoc,
   output logic o_end_of_sequence_strobe,
   output logic [15:0] o_result,
   output logic [4:0] o_channel,
   output logic o_converter_clock_tick,
   output logic [15:0] o_aux_positive_inputs_en,
   output logic [15:0] o_aux_negative_inputs_en,
   output logic [15:0] o_aux_digital_en,
   output logic [3:0] o_common_n_select
);

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   function automatic logic [8:0] avg_count(input logic lo,
                                            input logic hi);
      logic [8:0] n;
      case ({hi, lo})
         2'b01: n = AVG_16;
         2'b10: n = AVG_64;
         2'b11: n = AVG_256;
         default: n = AVG_NONE;
      endcase
      return n;
   endfunction

   function automatic logic [12:0] run_total(input logic seq_on,
                                             input logic [4:0] len,
                                             input logic [8:0] avg);
      logic [4:0] chans;
      logic [13:0] prod;
      chans = (seq_on && len != 5'h00) ? len : 5'h01;
      prod = 14'(chans) * 14'(avg);
      return prod[12:0];
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      asc_state_e state;
      logic [3:0] div_cnt;
      logic tick;
      logic [4:0] phase_cnt;
      logic pend;
      logic busy;
      logic [15:0] hold_result;
      logic [4:0] post_cnt;
      logic post_eos;
      logic [12:0] conv_cnt;
      logic eoc;
      logic end_of_sequence_strobe;
      logic [15:0] result;
      logic [4:0] channel;
      logic [15:0] aux_an;
      logic [15:0] aux_dig;
      logic [3:0] common_n;
   } asc_ctrl_s;

   asc_ctrl_s st;
   asc_ctrl_s next_st;
   logic start_rise;
   logic extend;
   logic [12:0] total;

   asc_start_sync u_start_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_conversion_start_pulse(i_conversion_start_pulse),
      .i_conversion_start_clock(i_conversion_start_clock),
      .o_start_rise(start_rise)
   );

   // Sequencer field applies to sequenced runs, single bit otherwise
   assign extend = i_sequencer_active ? (|i_sequencer_settling_field)
                                      : i_extended_settling_bit;
   assign total = run_total(i_sequencer_active, i_sequence_length,
      avg_count(i_averaging_select_low, i_averaging_select_high));

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.eoc = 1'b0;
      next_st.end_of_sequence_strobe = 1'b0;

      // Converter clock as a tick, so no second clock domain exists
      if (st.div_cnt == ADC_DIV - 4'h1) begin
         next_st.div_cnt = 4'h0;
         next_st.tick = 1'b1;
      end else begin
         next_st.div_cnt = st.div_cnt + 4'h1;
         next_st.tick = 1'b0;
      end

      // Starts during a conversion are dropped, not queued
      if (start_rise && st.state == ASC_IDLE) begin
         next_st.pend = 1'b1;
      end

      if (st.tick) begin
         case (st.state)
            ASC_IDLE: begin
               if (i_event_mode) begin
                  // Taken on a converter tick: resynchronised start
                  if (st.pend) begin
                     next_st.pend = 1'b0;
                     next_st.state = ASC_CONVERT;
                     next_st.phase_cnt = CONV_TICKS;
                     next_st.busy = 1'b1;
                     next_st.channel = i_next_channel;
                  end
               end else begin
                  next_st.pend = 1'b0;
                  next_st.state = ASC_SETTLE;
                  next_st.phase_cnt = extend ? SETTLE_LONG
                                             : SETTLE_SHORT;
               end
            end
            ASC_SETTLE: begin
               if (st.phase_cnt == 5'h01) begin
                  next_st.state = ASC_CONVERT;
                  next_st.phase_cnt = CONV_TICKS;
                  next_st.busy = 1'b1;
                  next_st.channel = i_next_channel;
               end else begin
                  next_st.phase_cnt = st.phase_cnt - 5'h01;
               end
            end
            ASC_CONVERT: begin
               if (st.phase_cnt == 5'h01) begin
                  // Busy falls first; result waits out the hand-off
                  next_st.busy = 1'b0;
                  next_st.hold_result = i_sample_code;
                  next_st.post_cnt = EOC_DELAY;
                  next_st.state = i_event_mode ? ASC_IDLE
                                               : ASC_SETTLE;
                  next_st.phase_cnt = extend ? SETTLE_LONG : SETTLE_SHORT;
               end else begin
                  next_st.phase_cnt = st.phase_cnt - 5'h01;
               end
            end
            default: begin
               next_st.state = ASC_IDLE;
            end
         endcase
      end

      // Result hand-off; a conversion is far longer than this wait
      if (st.post_cnt != 5'h00) begin
         next_st.post_cnt = st.post_cnt - 5'h01;
         if (st.post_cnt == 5'h01) begin
            next_st.result = st.hold_result;
            next_st.eoc = 1'b1;
            if (st.conv_cnt + 13'h0001 >= total) begin
               next_st.conv_cnt = 13'h0000;
               next_st.end_of_sequence_strobe = 1'b1;
            end else begin
               next_st.conv_cnt = st.conv_cnt + 13'h0001;
            end
         end
      end

      // Aux pins: connected pairs go analog, others stay digital
      next_st.aux_an = i_aux_connected;
      next_st.aux_dig = ~i_aux_connected;
      next_st.common_n = i_single_ended_analog_standard ?
                         i_common_n_source : COMMON_N_RESET;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_busy = st.busy;
   assign o_eoc = st.eoc;
   assign o_end_of_sequence_strobe = st.end_of_sequence_strobe;
   assign o_result = st.result;
   assign o_channel = st.channel;
   assign o_converter_clock_tick = st.tick;
   assign o_aux_positive_inputs_en = st.aux_an;
   // Negative enables follow every connected pair, in common negative mode too
   assign o_aux_negative_inputs_en = st.aux_an;
   assign o_aux_digital_en = st.aux_dig;
   assign o_common_n_select = st.common_n;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking chk_cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   localparam int BUSY_CYCLES = 220;
   localparam int TICK_GAP = 10;
   logic [8:0] busy_len;
   logic [3:0] tick_gap;
   // Strobes seen since the last end of sequence
   logic [12:0] eoc_seen;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         busy_len <= 9'h000;
         tick_gap <= 4'h0;
         eoc_seen <= 13'h0000;
      end else begin
         busy_len <= st.busy ? busy_len + 9'h001 : 9'h000;
         tick_gap <= st.tick ? 4'h1 : tick_gap + 4'h1;
         if (st.end_of_sequence_strobe) begin
            eoc_seen <= 13'h0000;
         end else if (st.eoc) begin
            eoc_seen <= eoc_seen + 13'h0001;
         end
      end
   end

   sequence busy_end_s;
      $fell(st.busy);
   endsequence

   sequence eoc_wait_s;
      ##15 !st.eoc ##1 st.eoc;
   endsequence

   sequence restart_short_s;
      ##40 $rose(st.busy);
   endsequence

   sequence restart_long_s;
      ##100 $rose(st.busy);
   endsequence

   busy_length_a: assert property (
      $fell(st.busy) |-> busy_len == 9'(BUSY_CYCLES))
      else $error("busy length wrong");

   busy_hold_a: assert property (
      st.busy && busy_len != 9'(BUSY_CYCLES - 1) |=> st.busy)
      else $error("conversion cut short");

   eoc_delay_a: assert property (
      busy_end_s |-> eoc_wait_s)
      else $error("eoc not sixteen cycles after busy fall");

   eoc_pulse_a: assert property (
      st.eoc |=> !st.eoc)
      else $error("eoc longer than one cycle");

   eoc_result_a: assert property (
      st.eoc |-> st.result == $past(st.hold_result))
      else $error("result not the held code");

   eos_with_eoc_a: assert property (
      st.end_of_sequence_strobe |-> st.eoc && st.result == st.hold_result)
      else $error("eos without eoc");

   eos_count_a: assert property (
      st.end_of_sequence_strobe |-> eoc_seen == total - 13'h0001)
      else $error("end of sequence at wrong count");

   event_start_a: assert property (
      (i_event_mode && $rose(st.busy)) |-> $past(st.pend))
      else $error("event conversion without start");

   event_hold_a: assert property (
      i_event_mode && st.state == ASC_IDLE && !st.pend |=> !st.busy)
      else $error("event conversion began unasked");

   pend_drop_a: assert property (
      st.state != ASC_IDLE && !st.pend |=> !st.pend)
      else $error("start queued during a conversion");

   settle_short_a: assert property (
      !i_event_mode && !extend && $fell(st.busy) |-> restart_short_s)
      else $error("short settle not four ticks");

   settle_long_a: assert property (
      !i_event_mode && extend && $fell(st.busy) |-> restart_long_s)
      else $error("long settle not ten ticks");

   tick_rate_a: assert property (
      st.tick |-> tick_gap == 4'(TICK_GAP))
      else $error("converter tick too fast");

   channel_latch_a: assert property (
      $rose(st.busy) |-> st.channel == $past(i_next_channel))
      else $error("channel not taken at busy rise");

   aux_split_a: assert property (
      $past(i_rst_n) |-> st.aux_an == $past(i_aux_connected) &&
         st.aux_dig == ~$past(i_aux_connected))
      else $error("aux pin both analog and digital");

   common_sel_a: assert property (
      $past(i_rst_n) && $past(i_single_ended_analog_standard) |->
         st.common_n == $past(i_common_n_source))
      else $error("common negative not the chosen source");

endmodule // asc_ctrl
`default_nettype wire

// ===== bench/asc_fabric.sv
// Fabric-side model that fires conversion starts on command
`timescale 1ns/100ps
`default_nettype none
module asc_fabric (
   input wire logic i_clk,
   input wire logic i_go_pulse,
   input wire logic i_go_clock,
   output logic o_start_pulse,
   output logic o_start_clock
);
   logic [1:0] pul_cnt = 2'h0;
   logic [2:0] clk_cnt = 3'h0;

   initial o_start_pulse = 1'b0;
   initial o_start_clock = 1'b0;

   // ------------------------------------------------------------
   // Start generation
   // ------------------------------------------------------------
   // One command gives one pulse, held two cycles
   always @(posedge i_clk) begin
      if (pul_cnt != 2'h0) pul_cnt <= pul_cnt - 2'h1;
      else if (i_go_pulse) pul_cnt <= 2'h2;
      if (clk_cnt != 3'h0) clk_cnt <= clk_cnt - 3'h1;
      else if (i_go_clock) clk_cnt <= 3'h6;
   end

   // Start clock toggles only in a short burst and rests low; the
   // channel is settled long before any command
   always @(negedge i_clk) begin
      o_start_pulse <= (pul_cnt != 2'h0);
      o_start_clock <= clk_cnt[0];
   end
endmodule // asc_fabric
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the conversion control block
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import asc_pkg::*;
;
   logic clk = 1'b0, rst_n = 1'b0, ev = 1'b0, ext = 1'b0, seqa = 1'b0;
   logic avl = 1'b0, avh = 1'b0, se = 1'b0, go_p = 1'b0, go_c = 1'b0;
   logic [2:0] seqf = 3'h0;
   logic [4:0] seqlen = 5'h00, nch = 5'h00;
   logic [15:0] code = 16'h0000, auxc = 16'h0000;
   logic [3:0] cns = 4'h0;
   wire logic sp, sc, busy, eoc, end_of_sequence_strobe, tick;
   wire logic [15:0] result, ape, ane, ade;
   wire logic [4:0] chan;
   wire logic [3:0] cnsel;
   int failures = 0, checked = 0, cycles = 0;

   always #10 clk = ~clk;

   asc_fabric i_fabric (.i_clk(clk), .i_go_pulse(go_p), .i_go_clock(go_c),
      .o_start_pulse(sp), .o_start_clock(sc));

   asc_ctrl i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_event_mode(ev),
      .i_extended_settling_bit(ext), .i_sequencer_settling_field(seqf),
      .i_sequencer_active(seqa), .i_sequence_length(seqlen),
      .i_averaging_select_low(avl), .i_averaging_select_high(avh),
      .i_next_channel(nch), .i_sample_code(code),
      .i_conversion_start_pulse(sp), .i_conversion_start_clock(sc),
      .i_aux_connected(auxc), .i_single_ended_analog_standard(se),
      .i_common_n_source(cns), .o_busy(busy), .o_eoc(eoc),
      .o_end_of_sequence_strobe(end_of_sequence_strobe), .o_result(result), .o_channel(chan),
      .o_converter_clock_tick(tick), .o_aux_positive_inputs_en(ape),
      .o_aux_negative_inputs_en(ane), .o_aux_digital_en(ade),
      .o_common_n_select(cnsel));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic ok, input string m);
      checked++;
      if (ok !== 1'b1) begin
         failures++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask

   task automatic do_reset();
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
   endtask

   task automatic wait_busy(input int lim, output int n);
      n = 0;
      while (busy !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk(busy === 1'b1, "busy did not rise");
   endtask

   // Entered one cycle after busy was first seen high
   task automatic one_conv(input logic exp_eos, input logic [15:0] c);
      int n;
      n = 1;
      while (busy === 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      chk(n == 220, "busy length");
      n = 0;
      while (eoc !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk(n == 16, "eoc delay");
      chk(result === c, "result value");
      chk(end_of_sequence_strobe === exp_eos, "eos with eoc");
      @(negedge clk);
      chk(eoc === 1'b0, "eoc width");
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Extended bit set on purpose: it must change nothing here
   task automatic t_event(input logic use_clk, input logic [15:0] c,
                          input logic [4:0] ch);
      int n;
      ev = 1'b1;
      ext = 1'b1;
      code = c;
      nch = ch;
      do_reset();
      repeat (40) @(negedge clk);
      chk(busy === 1'b0, "busy without start");
      if (use_clk) go_c = 1'b1;
      else go_p = 1'b1;
      @(negedge clk);
      go_c = 1'b0;
      go_p = 1'b0;
      wait_busy(20, n);
      chk(chan === ch, "channel at busy rise");
      go_p = 1'b1;
      @(negedge clk);
      go_p = 1'b0;
      one_conv(1'b1, c);
      n = 0;
      repeat (300) begin
         @(negedge clk);
         if (busy === 1'b1) n++;
      end
      chk(n == 0, "extra conversion");
   endtask

   task automatic t_cont(input logic e, input logic sa, input logic [2:0] sf,
                         input int per);
      int n;
      int m;
      ev = 1'b0;
      ext = e;
      seqa = sa;
      seqf = sf;
      seqlen = 5'h01;
      nch = 5'h03;
      do_reset();
      n = 0;
      while (tick !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      n = 1;
      while (tick !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk(n == 10, "tick spacing");
      wait_busy(400, n);
      nch = 5'h07;
      n = 0;
      while (busy === 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      m = n;
      wait_busy(400, n);
      chk(m == 220, "busy length");
      chk(m + n == per, "period");
      chk(chan === 5'h07, "channel from mode");
      $display("test continuous run done");
   endtask

   task automatic t_eos(input logic [4:0] len, input logic h, input logic l,
                        input int cnt);
      int k;
      int n;
      ev = 1'b0;
      ext = 1'b0;
      seqa = 1'b1;
      seqf = 3'h0;
      seqlen = len;
      avh = h;
      avl = l;
      do_reset();
      for (k = 1; k <= cnt; k++) begin
         n = 0;
         while (eoc !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
         end
         chk(eoc === 1'b1, "eoc in run");
         chk(end_of_sequence_strobe === (k == cnt), "eos placement");
         @(negedge clk);
      end
      $display("test sequence run done");
   endtask

   task automatic t_aux();
      do_reset();
      auxc = 16'hF00F;
      se = 1'b1;
      cns = 4'h5;
      @(negedge clk);
      chk(ape === 16'hF00F && ane === 16'hF00F, "aux on");
      chk(ade === 16'h0FF0, "digital use");
      chk(cnsel === 4'h5, "common source");
      se = 1'b0;
      @(negedge clk);
      chk(cnsel === 4'h0, "common default");
   endtask

   // ------------------------------------------------------------
   // Main sequence and hang guard
   // ------------------------------------------------------------
   // Ceiling sized for the long 256-sample run plus the rest
   always @(posedge clk) begin
      cycles++;
      if (cycles == 98000) begin
         failures++;
         print_verdict();
      end
   end

   initial begin
      t_aux();
      $display("test aux done");
      t_event(1'b0, 16'hA5C3, 5'h0B);
      $display("test event pulse done");
      t_event(1'b1, 16'h5A3C, 5'h13);
      $display("test event clock done");
      t_cont(1'b0, 1'b0, 3'h0, 260);
      t_cont(1'b1, 1'b0, 3'h0, 320);
      t_cont(1'b0, 1'b1, 3'h4, 320);
      t_eos(5'h02, 1'b0, 1'b0, 2);
      t_eos(5'h01, 1'b0, 1'b1, 16);
      t_eos(5'h01, 1'b1, 1'b0, 64);
      t_eos(5'h01, 1'b1, 1'b1, 256);
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
